// file: inc/replay_pkg.sv
// shared constants and types for the input replay memory control block
package replay_pkg;

    // ==========================================================
    // scrolling memory geometry
    localparam int unsigned SCROLL_DEPTH  = 256;
    localparam int unsigned SCROLL_ADDR_W = 8;
    localparam logic [7:0]  ADDR_RESET    = 8'h00;
    localparam logic [7:0]  ADDR_LAST     = 8'hff;

    // ==========================================================
    // slow-control endpoint
    localparam int unsigned DEST_ID_W     = 3;
    // arbitrary default, not tied to any real board
    localparam logic [2:0]  LOCAL_ID_DEF  = 3'h1;
    localparam logic        SEL_IN_MEM    = 1'b0;
    localparam logic        SEL_OUT_MEM   = 1'b1;

    // ==========================================================
    // status flag positions and reset value
    localparam int unsigned STAT_W        = 4;
    localparam int unsigned STAT_IN_REP   = 0;
    localparam int unsigned STAT_OUT_REP  = 1;
    localparam int unsigned STAT_WR_REP   = 2;
    localparam int unsigned STAT_FWD      = 3;
    localparam logic [3:0]  STAT_RESET    = 4'h0;

    // ==========================================================
    // pipeline depth from mode change to the data outputs
    localparam int unsigned PIPE_CYCLES   = 2;

    // ==========================================================
    // replay modes
    typedef enum logic [1:0] {
        MODE_LIVE   = 2'b00,
        MODE_IN     = 2'b01,
        MODE_IN_OUT = 2'b10
    } mode_t;

endpackage

// file: src/replay_control.sv
// replay control: live or scrolling-memory data into feature extraction and out
//
// Contract
// R01: replay starts only on the slow-control replay command input.
// R02: during replay live input words are ignored, memory words used instead.
// R03: replayed words drive the feature-extraction input in place of live data.
// R04: optional output replay drives real-time output from second memory set.
// R05: input memories always used in replay; output memories selectable.
// R06: one global replay setting covers all channels together.
// R07: replay selection and memory contents are loaded via slow control.
// R08: each scrolling memory holds exactly 256 words, one buffer.
// R09: status flags readable by slow control show block state.
// R10: local endpoint serves own writes; others are forwarded onward.
// R11: one word per cycle, address wraps modulo depth, playback repeats.
// R12: mode changes apply on a clock edge to whole words only.
`timescale 1ns/1ps
module replay_control #(
    parameter int unsigned DATA_W   = 64,
    parameter int unsigned OUT_W    = 32,
    parameter logic [2:0]  LOCAL_ID = replay_pkg::LOCAL_ID_DEF
) (
    input  wire logic                             ref_clk,
    input  wire logic                             rstn,
    input  wire logic                             replay_req,
    input  wire logic                             out_replay_req,
    input  wire logic [DATA_W-1:0]                live_data,
    input  wire logic [OUT_W-1:0]                 proc_result,
    output logic      [DATA_W-1:0]                fex_data,
    output logic      [OUT_W-1:0]                 rt_out_data,
    input  wire logic                             sc_wr_en,
    input  wire logic [replay_pkg::DEST_ID_W-1:0] sc_dest_id,
    input  wire logic                             sc_wr_sel,
    input  wire logic [7:0]                       sc_wr_addr,
    input  wire logic [DATA_W-1:0]                sc_wr_data,
    output logic                                  fwd_wr_en,
    output logic      [replay_pkg::DEST_ID_W-1:0] fwd_dest_id,
    output logic                                  fwd_wr_sel,
    output logic      [7:0]                       fwd_wr_addr,
    output logic      [DATA_W-1:0]                fwd_wr_data,
    input  wire logic                             status_clear,
    output logic      [replay_pkg::STAT_W-1:0]    status_flags
);

    // ==========================================================
    // reset release
    logic [1:0] rst_pipe_q;
    logic       rst_n_sync;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    // the block leaves reset on one edge, the second after the pin rises
    assign rst_n_sync = rst_pipe_q[1];

    // ==========================================================
    // state
    typedef struct packed {
        replay_pkg::mode_t                mode;
        logic [7:0]                       addr;
        logic                             in_rep_p;
        logic                             out_rep_p;
        logic [DATA_W-1:0]                live_p;
        logic [OUT_W-1:0]                 res_p;
        logic [DATA_W-1:0]                fex;
        logic [OUT_W-1:0]                 rt_out;
        logic                             fwd_en;
        logic [replay_pkg::DEST_ID_W-1:0] fwd_id;
        logic                             fwd_sel;
        logic [7:0]                       fwd_addr;
        logic [DATA_W-1:0]                fwd_data;
        logic [replay_pkg::STAT_W-1:0]    stat;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ==========================================================
    // helpers
    function automatic logic local_write(input logic en, input logic [2:0] id,
                                         input logic sel, input logic want);
        return en && (id == LOCAL_ID) && (sel == want);
    endfunction

    function automatic replay_pkg::mode_t decode_mode(input logic rep, input logic orep);
        // output replay alone is meaningless: input memories are mandatory
        if (!rep) begin
            return replay_pkg::MODE_LIVE;
        end
        return orep ? replay_pkg::MODE_IN_OUT : replay_pkg::MODE_IN;
    endfunction

    // ==========================================================
    // scrolling memories
    logic              in_wr;
    logic              out_wr;
    logic [DATA_W-1:0] in_rd_data;
    logic [OUT_W-1:0]  out_rd_data;
    logic              replaying;

    // R07 memory load path
    assign in_wr  = local_write(sc_wr_en, sc_dest_id, sc_wr_sel, replay_pkg::SEL_IN_MEM);
    assign out_wr = local_write(sc_wr_en, sc_dest_id, sc_wr_sel, replay_pkg::SEL_OUT_MEM);
    // one mode register feeds every channel select, never a per-channel bit
    assign replaying = (state_q.mode != replay_pkg::MODE_LIVE);

    // R08 depth-256 buffers
    scroll_memory #(
        .WIDTH  (DATA_W),
        .DEPTH  (replay_pkg::SCROLL_DEPTH),
        .ADDR_W (replay_pkg::SCROLL_ADDR_W)
    ) u_in_mem (
        .clk     (ref_clk),
        .wr_en   (in_wr),
        .wr_addr (sc_wr_addr),
        .wr_data (sc_wr_data),
        .rd_addr (state_q.addr),
        .rd_data (in_rd_data)
    );

    scroll_memory #(
        .WIDTH  (OUT_W),
        .DEPTH  (replay_pkg::SCROLL_DEPTH),
        .ADDR_W (replay_pkg::SCROLL_ADDR_W)
    ) u_out_mem (
        .clk     (ref_clk),
        .wr_en   (out_wr),
        .wr_addr (sc_wr_addr),
        .wr_data (sc_wr_data[OUT_W-1:0]),
        .rd_addr (state_q.addr),
        .rd_data (out_rd_data)
    );

    // ==========================================================
    // next state
    always_comb begin
        state_d = state_q;

        // R01 mode from the command inputs
        // R12 registered once, so both data muxes switch on one edge
        state_d.mode = decode_mode(replay_req, out_replay_req);

        // R11 address steps every cycle while replaying and wraps, held at zero in live mode
        state_d.addr = replaying ? 8'(state_q.addr + 8'h01) : replay_pkg::ADDR_RESET;

        // delay live data and select bits to line up with the memory read
        // the read costs one edge, so live words and selects wait one edge too
        state_d.live_p = live_data;
        state_d.res_p  = proc_result;
        unique case (state_q.mode)
            replay_pkg::MODE_LIVE: begin
                state_d.in_rep_p  = 1'b0;
                state_d.out_rep_p = 1'b0;
            end
            replay_pkg::MODE_IN: begin
                state_d.in_rep_p  = 1'b1;
                state_d.out_rep_p = 1'b0;
            end
            replay_pkg::MODE_IN_OUT: begin
                state_d.in_rep_p  = 1'b1;
                state_d.out_rep_p = 1'b1;
            end
            default: begin
                state_d.in_rep_p  = 1'b0;
                state_d.out_rep_p = 1'b0;
            end
        endcase

        // R02 R03 R06 one select for the whole word of all channels
        state_d.fex = state_q.in_rep_p ? in_rd_data : state_q.live_p;
        // R04 R05 output memories only when selected
        state_d.rt_out = state_q.out_rep_p ? out_rd_data : state_q.res_p;

        // R10 writes for other devices pass on one cycle later
        state_d.fwd_en   = sc_wr_en && (sc_dest_id != LOCAL_ID);
        state_d.fwd_id   = sc_dest_id;
        state_d.fwd_sel  = sc_wr_sel;
        state_d.fwd_addr = sc_wr_addr;
        state_d.fwd_data = sc_wr_data;

        // R09 status, sticky bits set wins over clear
        state_d.stat[replay_pkg::STAT_IN_REP]  = replaying;
        state_d.stat[replay_pkg::STAT_OUT_REP] =
            (state_q.mode == replay_pkg::MODE_IN_OUT);
        state_d.stat[replay_pkg::STAT_WR_REP] =
            ((in_wr || out_wr) && replaying) ||
            (state_q.stat[replay_pkg::STAT_WR_REP] && !status_clear);
        state_d.stat[replay_pkg::STAT_FWD] =
            state_d.fwd_en || (state_q.stat[replay_pkg::STAT_FWD] && !status_clear);
    end

    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_q           <= '0;
            state_q.mode      <= replay_pkg::MODE_LIVE;
            state_q.addr      <= replay_pkg::ADDR_RESET;
            state_q.stat      <= replay_pkg::STAT_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // outputs
    // loading while replaying is allowed, but the flag warns of torn playback
    assign fex_data     = state_q.fex;
    assign rt_out_data  = state_q.rt_out;
    assign fwd_wr_en    = state_q.fwd_en;
    assign fwd_dest_id  = state_q.fwd_id;
    assign fwd_wr_sel   = state_q.fwd_sel;
    assign fwd_wr_addr  = state_q.fwd_addr;
    assign fwd_wr_data  = state_q.fwd_data;
    assign status_flags = state_q.stat;

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_sync);

    a_mode_follows_cmd: assert property ( // R01
        ##1 state_q.mode == decode_mode($past(replay_req), $past(out_replay_req)))
        else $error("mode does not follow command inputs");

    // pipeline registers still hold reset zeros for two edges after release
    a_live_to_fex: assert property ( // R02
        ($past(rst_n_sync) && state_q.mode == replay_pkg::MODE_LIVE) |->
            ##2 fex_data == $past(live_data, 2))
        else $error("live data not passed in live mode");

    a_replay_to_fex: assert property ( // R03
        replaying |-> ##2 fex_data == $past(in_rd_data))
        else $error("replay word not at feature input");

    a_out_from_mem: assert property ( // R04
        (state_q.mode == replay_pkg::MODE_IN_OUT) |-> ##2 rt_out_data == $past(out_rd_data))
        else $error("output replay word not driven");

    a_out_from_proc: assert property ( // R05
        ($past(rst_n_sync) && state_q.mode != replay_pkg::MODE_IN_OUT) |-> ##2
            rt_out_data == $past(proc_result, 2))
        else $error("processing result not driven");

    a_addr_step: assert property ( // R11
        replaying |=> state_q.addr == 8'($past(state_q.addr) + 8'h01))
        else $error("replay address did not advance");

    a_addr_wrap: assert property ( // R08
        (replaying && state_q.addr == replay_pkg::ADDR_LAST) |=>
            state_q.addr == replay_pkg::ADDR_RESET)
        else $error("replay address did not wrap at depth");

    a_addr_idle_zero: assert property ( // R11
        !replaying |=> state_q.addr == replay_pkg::ADDR_RESET)
        else $error("address not parked in live mode");

    a_fwd_pass: assert property ( // R10
        (sc_wr_en && sc_dest_id != LOCAL_ID) |=>
            fwd_wr_en && fwd_wr_data == $past(sc_wr_data) && fwd_wr_addr == $past(sc_wr_addr))
        else $error("foreign write not forwarded");

    a_local_no_fwd: assert property ( // R10
        (sc_dest_id == LOCAL_ID) |=> !fwd_wr_en)
        else $error("local write forwarded");

    a_status_mode: assert property ( // R09
        ##1 status_flags[replay_pkg::STAT_IN_REP] == $past(replaying))
        else $error("status replay flag wrong");

    a_sticky_set_wins: assert property ( // R09
        ((in_wr || out_wr) && replaying && status_clear) |=>
            status_flags[replay_pkg::STAT_WR_REP])
        else $error("sticky flag lost under clear");

    a_clear_drops: assert property ( // R09
        (status_clear && !sc_wr_en) |=>
            !status_flags[replay_pkg::STAT_WR_REP] && !status_flags[replay_pkg::STAT_FWD])
        else $error("sticky flags survive a clear");

    a_fwd_flagged: assert property ( // R09
        fwd_wr_en |-> status_flags[replay_pkg::STAT_FWD])
        else $error("forwarded write not flagged");

    a_fwd_one_cycle: assert property ( // R10
        !sc_wr_en |=> !fwd_wr_en)
        else $error("forward strobe without a write");

    // output replay alone would leave feature extraction on live data
    a_out_needs_in: assert property ( // R05
        status_flags[replay_pkg::STAT_OUT_REP] |-> status_flags[replay_pkg::STAT_IN_REP])
        else $error("output replay flagged without input replay");

    a_out_flag: assert property ( // R09
        ##1 status_flags[replay_pkg::STAT_OUT_REP] ==
            ($past(state_q.mode) == replay_pkg::MODE_IN_OUT))
        else $error("status output replay flag wrong");

    c_enter_replay: cover property (!replaying ##1 replaying);
    c_addr_wrap: cover property (replaying && state_q.addr == replay_pkg::ADDR_LAST);
    c_out_replay: cover property (state_q.mode == replay_pkg::MODE_IN_OUT);
    c_forward: cover property (fwd_wr_en);
    c_set_beats_clear: cover property ((in_wr || out_wr) && replaying && status_clear);

endmodule

// file: src/scroll_memory.sv
// scrolling memory: one write port, one registered read port
`timescale 1ns/1ps
module scroll_memory #(
    parameter int unsigned WIDTH  = 32,
    parameter int unsigned DEPTH  = replay_pkg::SCROLL_DEPTH,
    parameter int unsigned ADDR_W = replay_pkg::SCROLL_ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WIDTH-1:0]  rd_data
);

    // ==========================================================
    // storage
    // no reset on the array so it maps onto block ram
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rd_q;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_q <= mem_q[rd_addr];
    end

    assign rd_data = rd_q;

endmodule

// file: testbench/input_replay_memory_control_tb_top.sv
// testbench for the replay control block with a slow-control master model
`timescale 1ns/1ps
module input_replay_memory_control_tb_top;
    localparam int unsigned DW = 16;
    localparam int unsigned OW = 8;
    typedef struct {
        logic [DW-1:0] live;
        logic [OW-1:0] proc;
        logic          oreq;
        logic [DW-1:0] exp_fex;
        logic [OW-1:0] exp_rt;
    } row_t;
    logic          ref_clk = 1'b0;
    logic          rstn = 1'b0;
    logic          cmd_valid = 1'b0, cmd_sel = 1'b0, replay_cmd = 1'b0, out_replay_cmd = 1'b0;
    logic [2:0]    cmd_dest = 3'h0, sc_dest_id, fwd_dest_id;
    logic [7:0]    cmd_addr = 8'h00, sc_wr_addr, fwd_wr_addr;
    logic [DW-1:0] cmd_data = 16'h0000, live_data = 16'h0000, sc_wr_data, fex_data, fwd_wr_data;
    logic [OW-1:0] proc_result = 8'h00, rt_out_data;
    logic          sc_wr_en, sc_wr_sel, replay_req, out_replay_req, fwd_wr_en, fwd_wr_sel;
    logic          status_clear = 1'b0;
    logic [3:0]    status_flags;
    int            errors = 0;
    int            comparisons = 0;
    row_t          rows [4] = '{
        '{16'h0001, 8'h10, 1'b0, 16'h0001, 8'h10}, '{16'hffff, 8'hff, 1'b1, 16'hffff, 8'hff},
        '{16'ha5a5, 8'h3c, 1'b1, 16'ha5a5, 8'h3c}, '{16'h0000, 8'h00, 1'b0, 16'h0000, 8'h00}};

    sc_master_model partner (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_dest(cmd_dest),
        .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .replay_cmd(replay_cmd),
        .out_replay_cmd(out_replay_cmd), .sc_wr_en(sc_wr_en), .sc_dest_id(sc_dest_id),
        .sc_wr_sel(sc_wr_sel), .sc_wr_addr(sc_wr_addr), .sc_wr_data(sc_wr_data),
        .replay_req(replay_req), .out_replay_req(out_replay_req));
    replay_control #(.DATA_W(DW), .OUT_W(OW)) uut (.ref_clk(ref_clk), .rstn(rstn),
        .replay_req(replay_req), .out_replay_req(out_replay_req), .live_data(live_data),
        .proc_result(proc_result), .fex_data(fex_data), .rt_out_data(rt_out_data),
        .sc_wr_en(sc_wr_en), .sc_dest_id(sc_dest_id), .sc_wr_sel(sc_wr_sel),
        .sc_wr_addr(sc_wr_addr), .sc_wr_data(sc_wr_data), .fwd_wr_en(fwd_wr_en),
        .fwd_dest_id(fwd_dest_id), .fwd_wr_sel(fwd_wr_sel), .fwd_wr_addr(fwd_wr_addr),
        .fwd_wr_data(fwd_wr_data), .status_clear(status_clear), .status_flags(status_flags));

    // ==========================================================
    // clock, watchdog and shared tasks
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        close_out();
    end
    function automatic logic [DW-1:0] in_word(input logic [7:0] k);
        return {k ^ 8'ha5, k};
    endfunction
    function automatic logic [OW-1:0] out_word(input logic [7:0] k);
        return k ^ 8'h5a;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // back-to-back capable: strobe stays up until the caller drops it
    task automatic wr(input logic [2:0] d, input logic s, input logic [7:0] a,
                      input logic [DW-1:0] v);
        cmd_valid = 1'b1;
        cmd_dest = d;
        cmd_sel = s;
        cmd_addr = a;
        cmd_data = v;
        tick(1);
    endtask
    task automatic play(input logic oreq);
        replay_cmd = 1'b1;
        out_replay_cmd = oreq;
        tick(4);
        for (int k = 0; k < 260; k++) begin
            chk(fex_data, in_word(k[7:0]));
            chk(16'(rt_out_data), 16'(oreq ? out_word(k[7:0]) : proc_result));
            chk(16'(status_flags[1:0]), {14'h0, oreq, 1'b1});
            live_data = ~in_word(k[7:0]);
            tick(1);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        tick(10);
        chk(fex_data, 16'h0000);
        chk(16'({status_flags, fwd_wr_en}), 16'h0000);
        tick(6);
        rstn = 1'b1;
        tick(4);
        for (int i = 0; i < 4; i++) begin
            live_data = rows[i].live;
            proc_result = rows[i].proc;
            out_replay_cmd = rows[i].oreq;
            tick(4);
            chk(fex_data, rows[i].exp_fex);
            chk(16'(rt_out_data), 16'(rows[i].exp_rt));
            chk(16'(status_flags[1:0]), 16'h0000);
        end
        out_replay_cmd = 1'b0;
        for (int i = 0; i < 256; i++) begin
            wr(replay_pkg::LOCAL_ID_DEF, replay_pkg::SEL_IN_MEM, i[7:0], in_word(i[7:0]));
        end
        for (int i = 0; i < 256; i++) begin
            wr(replay_pkg::LOCAL_ID_DEF, replay_pkg::SEL_OUT_MEM, i[7:0], 16'(out_word(i[7:0])));
        end
        cmd_valid = 1'b0;
        tick(3);
        chk(16'(status_flags), 16'h0000);
        play(1'b0);
        wr(replay_pkg::LOCAL_ID_DEF, replay_pkg::SEL_IN_MEM, 8'h00, in_word(8'h00));
        cmd_valid = 1'b0;
        tick(1);
        chk(16'(status_flags[2]), 16'h0001);
        wr(3'h2, replay_pkg::SEL_OUT_MEM, 8'h05, 16'h1234);
        cmd_valid = 1'b0;
        tick(1);
        chk(16'({fwd_wr_en, fwd_dest_id, fwd_wr_sel, fwd_wr_addr}), 16'h1505);
        chk(fwd_wr_data, 16'h1234);
        chk(16'(status_flags[3]), 16'h0001);
        tick(1);
        chk(16'(fwd_wr_en), 16'h0000);
        status_clear = 1'b1;
        tick(1);
        status_clear = 1'b0;
        chk(16'(status_flags), 16'h0001);
        replay_cmd = 1'b0;
        tick(6);
        play(1'b1);
        replay_cmd = 1'b0;
        out_replay_cmd = 1'b0;
        live_data = 16'h7e81;
        tick(4);
        chk(fex_data, 16'h7e81);
        replay_cmd = 1'b1;
        tick(6);
        wr(replay_pkg::LOCAL_ID_DEF, replay_pkg::SEL_IN_MEM, 8'h00, in_word(8'h00));
        cmd_valid = 1'b0;
        status_clear = 1'b1;
        tick(1);
        status_clear = 1'b0;
        chk(16'(status_flags[2]), 16'h0001);
        tick(1);
        rstn = 1'b0;
        replay_cmd = 1'b0;
        tick(1);
        chk(16'({status_flags, fwd_wr_en}), 16'h0000);
        chk(fex_data, 16'h0000);
        rstn = 1'b1;
        tick(4);
        chk(fex_data, 16'h7e81);
        chk(16'({status_flags, rt_out_data}), 16'h0000);
        close_out();
    end
endmodule

// file: testbench/sc_master_model.sv
// slow-control master model: replay commands and memory writes on ref_clk
`timescale 1ns/1ps
module sc_master_model (
    input  wire logic        ref_clk,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_dest,
    input  wire logic        cmd_sel,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [15:0] cmd_data,
    input  wire logic        replay_cmd,
    input  wire logic        out_replay_cmd,
    output logic             sc_wr_en,
    output logic      [2:0]  sc_dest_id,
    output logic             sc_wr_sel,
    output logic      [7:0]  sc_wr_addr,
    output logic      [15:0] sc_wr_data,
    output logic             replay_req,
    output logic             out_replay_req
);
    initial begin
        {sc_wr_en, sc_dest_id, sc_wr_sel, sc_wr_addr, sc_wr_data} = '0;
        {replay_req, out_replay_req} = 2'h0;
    end
    // ==========================================================
    // launch on the rising edge
    always @(posedge ref_clk) begin
        replay_req     <= replay_cmd;
        out_replay_req <= out_replay_cmd;
        sc_wr_en <= cmd_valid;
        if (cmd_valid) begin
            sc_dest_id <= cmd_dest;
            sc_wr_sel  <= cmd_sel;
            sc_wr_addr <= cmd_addr;
            sc_wr_data <= cmd_data;
        end else begin
            // idle address and data lines toggle so a stale word is never mistaken for data
            sc_wr_addr <= ~sc_wr_addr;
            sc_wr_data <= ~sc_wr_data;
        end
    end
endmodule
